// [sis_pkg.sv]
// How it works
// - Sample clock runs at 2 to 128 MHz, chosen by a rate select.
// - Clock drift within 100 ppm needs no reset; larger changes need a full reset.
// - The on-tick sample is taken with the tick, then one bit per 2^k cycles.
// - Each stream is sampled once per 2^k cycles, k clamped so rate never falls below 2 Mbps.
// - Thirty-two parallel stream lanes, 0 to 31, sampled together.
// - Stream rates of clock / 2^k, from 2 Mbps up to the clock rate, are selectable.
// - Alternate second tick may be asynchronous; one cycle ambiguity is accepted.
// - A single alternate tick pulse is enough to set the observe-time counter.
// - Aux serial input decodes 8-bit characters, 115 kbaud, one stop, no parity.
// - At most 2048 aux bytes are accepted per second interval.
// - Optionally, aux bytes carry the next second and update the counter.
// - Epoch monitor output pulses once per second while the counter is synchronised.
package sis_pkg;
  localparam int LANES = 32;
  localparam int RATE_W = 3;
  localparam int K_W = 3;
  localparam int PHASE_W = 7;
  localparam int SUB_W = 27;
  localparam int SEC_W = 32;
  localparam int MON_W = 21;
  localparam int BAUD_W = 11;
  localparam int BYTE_CNT_W = 12;
  localparam int AUX_BITS = 8;
  localparam int CFG_W = 8;
  localparam logic [RATE_W-1:0] RATE_MAX = 3'h6;
  localparam int BASE_HZ = 2_000_000;
  localparam int AUX_BAUD = 115_200;
  localparam int MON_TIME_MS = 10;
  localparam int MON_PER_SEC = 1000 / MON_TIME_MS;
  localparam logic [BYTE_CNT_W-1:0] AUX_MAX_BYTES = 12'h800;
  localparam logic [BYTE_CNT_W-1:0] AUX_TIME_BYTES = 12'h004;
  localparam logic [2:0] AUX_LAST_BIT = 3'h7;

  typedef enum logic [1:0] {SIS_UNSET, SIS_ARMED, SIS_RUNNING} sis_epoch_e;
  typedef enum logic [1:0] {SIS_RX_IDLE, SIS_RX_START, SIS_RX_DATA, SIS_RX_STOP} sis_rx_e;

  function automatic logic [SUB_W-1:0] cycles_per_sec(input logic [RATE_W-1:0] rate);
    cycles_per_sec = SUB_W'(BASE_HZ) << rate;
  endfunction

  function automatic logic [BAUD_W-1:0] baud_cycles(input logic [RATE_W-1:0] rate);
    baud_cycles = '0;
    for (int i = 0; i <= 6; i++) begin
      if (rate == RATE_W'(i)) begin
        baud_cycles = BAUD_W'((BASE_HZ << i) / AUX_BAUD);
      end
    end
  endfunction

  function automatic logic [MON_W-1:0] mon_cycles(input logic [RATE_W-1:0] rate);
    mon_cycles = '0;
    for (int i = 0; i <= 6; i++) begin
      if (rate == RATE_W'(i)) begin
        mon_cycles = MON_W'((BASE_HZ << i) / MON_PER_SEC);
      end
    end
  endfunction
endpackage

// [sis_source_model.sv]
`timescale 1ns/100ps
module sis_source_model #(
  parameter int BIT_CYCLES = 555
) (
  input wire logic sample_clk_i,
  input wire logic tick_req_i,
  input wire logic byte_req_i,
  input wire logic [7:0] byte_i,
  input wire logic stop_ok_i,
  output logic second_tick_o,
  output logic [31:0] lanes_o,
  output logic serial_o
);
  logic tick_seen = 1'b0;
  logic byte_seen = 1'b0;
  logic [15:0] phase = 16'h0000;
  logic [9:0] frame = 10'h3FF;
  logic [9:0] bit_cnt = 10'h000;
  logic [3:0] bits_left = 4'h0;
  initial begin
    second_tick_o = 1'b0;
    lanes_o = 32'h0000_0000;
    serial_o = 1'b1;
  end
  always @(posedge sample_clk_i) begin
    tick_seen <= tick_req_i;
    if (tick_req_i != tick_seen) begin
      second_tick_o <= 1'b1;
      phase <= 16'h0000;
      lanes_o <= {16'h0000, 16'hFFFF};
    end else begin
      second_tick_o <= 1'b0;
      phase <= phase + 16'h0001;
      lanes_o <= {phase + 16'h0001, ~(phase + 16'h0001)};
    end
  end
  always @(posedge sample_clk_i) begin
    byte_seen <= byte_req_i;
    if (byte_req_i != byte_seen) begin
      frame <= {stop_ok_i, byte_i, 1'b0};
      bits_left <= 4'hA;
      bit_cnt <= 10'h000;
    end else if (bits_left != 4'h0) begin
      serial_o <= frame[0];
      if (bit_cnt == 10'(BIT_CYCLES - 1)) begin
        bit_cnt <= 10'h000;
        frame <= {1'b1, frame[9:1]};
        bits_left <= bits_left - 4'h1;
      end else begin
        bit_cnt <= bit_cnt + 10'h001;
      end
    end else begin
      serial_o <= 1'b1;
    end
  end
endmodule

// [sis_stream_input_sampler.sv]
`timescale 1ns/100ps
module sis_stream_input_sampler (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] rate_sel_i,
  input wire logic [2:0] decim_k_i,
  input wire logic alt_select_i,
  input wire logic auto_time_i,
  input wire logic arm_i,
  input wire logic [31:0] set_seconds_i,
  input wire logic data_ready_i,
  output logic [31:0] data_o,
  output logic data_on_tick_o,
  output logic data_valid_o,
  output logic [7:0] aux_byte_o,
  output logic aux_valid_o,
  output logic time_set_o,
  output logic sample_overflow_o,
  output logic aux_overflow_o,
  input wire logic sample_clk_i,
  input wire logic second_tick_in_i,
  input wire logic alternate_second_tick_i,
  input wire logic [31:0] sample_stream_in_i,
  input wire logic aux_serial_in_i,
  output logic epoch_monitor_out_o
);
  // Control side, clk_i domain.
  logic [sis_pkg::CFG_W-1:0] cfg_q;
  logic arm_tog;
  logic [sis_pkg::SEC_W-1:0] pend_sec;
  logic [1:0] req_sync;
  logic s_ack;
  logic [1:0] aux_req_sync;
  logic aux_ack;
  logic [2:0] st_s1;
  logic [sis_pkg::LANES:0] head;
  logic [sis_pkg::LANES:0] tail;
  logic head_v;
  logic tail_v;
  logic push;
  logic pop;

  // Link side, sample_clk_i domain.
  logic lrst_s1;
  logic lrst_n;
  logic [sis_pkg::CFG_W-1:0] cfg_s1;
  logic [sis_pkg::CFG_W-1:0] cfg_s2;
  logic [2:0] arm_s;
  logic tick_s1, tick_s2, tick_s3;
  logic alt_s1, alt_s2, alt_s3;
  logic [sis_pkg::LANES-1:0] stream_s1;
  logic [sis_pkg::LANES-1:0] stream_s2;
  logic aux_s1, aux_s2, aux_s3;
  logic [1:0] ack_sync;
  logic [1:0] aux_ack_sync;
  sis_pkg::sis_epoch_e state;
  logic [sis_pkg::SEC_W-1:0] seconds;
  logic [sis_pkg::SUB_W-1:0] sub;
  logic [sis_pkg::PHASE_W-1:0] phase;
  logic [sis_pkg::MON_W-1:0] mon;
  logic s_req;
  logic [sis_pkg::LANES-1:0] s_word;
  logic s_tick;
  logic s_ovf;
  sis_pkg::sis_rx_e rx_state;
  logic [sis_pkg::BAUD_W-1:0] baud_cnt;
  logic [2:0] bit_idx;
  logic [sis_pkg::AUX_BITS-1:0] rx_shift;
  logic rx_done;
  logic aux_req;
  logic [sis_pkg::AUX_BITS-1:0] aux_hold;
  logic aux_ovf;
  logic [sis_pkg::BYTE_CNT_W-1:0] byte_cnt;
  logic [sis_pkg::SEC_W-1:0] aux_time;

  logic [2:0] rate;
  logic [2:0] k;
  logic [sis_pkg::PHASE_W-1:0] mask;
  logic [sis_pkg::SUB_W-1:0] cps;
  logic [sis_pkg::BAUD_W-1:0] bd;
  logic tick_edge, alt_edge, sel_edge, arm_req;
  logic epoch_now, sample_now;
  logic [sis_pkg::BYTE_CNT_W-1:0] byte_eff;

  // ---------------- clk_i domain ----------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg_q <= '0;
      arm_tog <= 1'b0;
      pend_sec <= '0;
    end else begin
      cfg_q <= {auto_time_i, alt_select_i, decim_k_i, rate_sel_i};
      if (arm_i) begin
        pend_sec <= set_seconds_i;
        arm_tog <= ~arm_tog;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      req_sync <= '0;
      aux_req_sync <= '0;
      st_s1 <= '0;
      time_set_o <= 1'b0;
      sample_overflow_o <= 1'b0;
      aux_overflow_o <= 1'b0;
    end else begin
      req_sync <= {req_sync[0], s_req};
      aux_req_sync <= {aux_req_sync[0], aux_req};
      st_s1 <= {aux_ovf, s_ovf, state == sis_pkg::SIS_RUNNING};
      time_set_o <= st_s1[0];
      sample_overflow_o <= st_s1[1];
      aux_overflow_o <= st_s1[2];
    end
  end

  // A waiting word is taken only while the tail slot is free.
  assign push = (req_sync[1] != s_ack) && !tail_v;
  assign pop = head_v && data_ready_i;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_ack <= 1'b0;
      head <= '0;
      tail <= '0;
      head_v <= 1'b0;
      tail_v <= 1'b0;
    end else begin
      if (push) begin
        s_ack <= ~s_ack;
      end
      if (!head_v || pop) begin
        if (tail_v) begin
          head <= tail;
        end else if (push) begin
          head <= {s_tick, s_word};
        end
      end
      head_v <= tail_v || push || (head_v && !pop);
      if (push && head_v && !pop) begin
        tail <= {s_tick, s_word};
        tail_v <= 1'b1;
      end else if (pop) begin
        tail_v <= 1'b0;
      end
    end
  end

  assign data_o = head[sis_pkg::LANES-1:0];
  assign data_on_tick_o = head[sis_pkg::LANES];
  assign data_valid_o = head_v;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aux_ack <= 1'b0;
      aux_byte_o <= '0;
      aux_valid_o <= 1'b0;
    end else begin
      aux_valid_o <= 1'b0;
      if (aux_req_sync[1] != aux_ack) begin
        aux_byte_o <= aux_hold;
        aux_valid_o <= 1'b1;
        aux_ack <= ~aux_ack;
      end
    end
  end

  // ---------------- sample_clk_i domain ----------------
  // the link side follows the module reset.
  always_ff @(posedge sample_clk_i) begin
    lrst_s1 <= rst_n_i;
    lrst_n <= lrst_s1;
  end

  // tick and lanes pass equal delays, so alignment is kept.
  // all 32 lanes are captured together.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
      alt_s1 <= 1'b0;
      alt_s2 <= 1'b0;
      alt_s3 <= 1'b0;
      stream_s1 <= '0;
      stream_s2 <= '0;
      aux_s1 <= 1'b1;
      aux_s2 <= 1'b1;
      aux_s3 <= 1'b1;
      cfg_s1 <= '0;
      cfg_s2 <= '0;
      arm_s <= '0;
      ack_sync <= '0;
      aux_ack_sync <= '0;
    end else begin
      tick_s1 <= second_tick_in_i;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
      // alternate tick synchronised, one cycle ambiguity.
      alt_s1 <= alternate_second_tick_i;
      alt_s2 <= alt_s1;
      alt_s3 <= alt_s2;
      stream_s1 <= sample_stream_in_i;
      stream_s2 <= stream_s1;
      aux_s1 <= aux_serial_in_i;
      aux_s2 <= aux_s1;
      aux_s3 <= aux_s2;
      cfg_s1 <= cfg_q;
      cfg_s2 <= cfg_s1;
      arm_s <= {arm_s[1:0], arm_tog};
      ack_sync <= {ack_sync[0], s_ack};
      aux_ack_sync <= {aux_ack_sync[0], aux_ack};
    end
  end

  always_comb begin
    // rate select clamped to the supported set.
    rate = (cfg_s2[2:0] > sis_pkg::RATE_MAX) ? sis_pkg::RATE_MAX : cfg_s2[2:0];
    // k clamped so the stream rate never falls below 2 Mbps.
    // any k from 0 up to the rate index is accepted.
    k = (cfg_s2[5:3] > rate) ? rate : cfg_s2[5:3];
    mask = ~({sis_pkg::PHASE_W{1'b1}} << k);
    cps = sis_pkg::cycles_per_sec(rate);
    bd = sis_pkg::baud_cycles(rate);
    tick_edge = tick_s2 && !tick_s3;
    alt_edge = alt_s2 && !alt_s3;
    sel_edge = cfg_s2[6] ? alt_edge : tick_edge;
    arm_req = arm_s[2] ^ arm_s[1];
    epoch_now = (state == sis_pkg::SIS_RUNNING) ? (sub == '0) : sel_edge;
    // on-tick sample, then one per 2^k cycles.
    sample_now = epoch_now || ((phase & mask) == '0);
    byte_eff = epoch_now ? '0 : byte_cnt;
  end

  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      state <= sis_pkg::SIS_UNSET;
    end else begin
      case (state)
        sis_pkg::SIS_UNSET: begin
          if (arm_req) begin
            state <= sis_pkg::SIS_ARMED;
          end
        end
        // one tick edge is enough to set the counter.
        sis_pkg::SIS_ARMED: begin
          if (sel_edge) begin
            state <= sis_pkg::SIS_RUNNING;
          end
        end
        sis_pkg::SIS_RUNNING: begin
          if (arm_req) begin
            state <= sis_pkg::SIS_ARMED;
          end
        end
        default: begin
          state <= sis_pkg::SIS_UNSET;
        end
      endcase
    end
  end

  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      seconds <= '0;
      sub <= '0;
    end else if (state == sis_pkg::SIS_ARMED && sel_edge) begin
      seconds <= pend_sec;
      sub <= 27'h0000001;
    end else if (state == sis_pkg::SIS_RUNNING) begin
      // the counter advances on clock cycles only.
      if (sub >= cps - 27'h0000001) begin
        sub <= '0;
        seconds <= seconds + 32'h00000001;
      end else begin
        sub <= sub + 27'h0000001;
      end
      // aux time loaded at the counter second when enabled.
      if (sub == '0 && cfg_s2[7] && byte_cnt >= sis_pkg::AUX_TIME_BYTES) begin
        seconds <= aux_time;
      end
    end
  end

  // phase restarts at each accepted tick.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      phase <= '0;
    end else if (epoch_now) begin
      phase <= 7'h01;
    end else begin
      phase <= phase + 7'h01;
    end
  end

  // stretched monitor pulse at each counter second.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      mon <= '0;
      epoch_monitor_out_o <= 1'b0;
    end else if (epoch_now && state != sis_pkg::SIS_UNSET) begin
      mon <= sis_pkg::mon_cycles(rate);
      epoch_monitor_out_o <= 1'b1;
    end else begin
      if (mon != '0) begin
        mon <= mon - 21'h000001;
      end
      epoch_monitor_out_o <= (mon > 21'h000001);
    end
  end

  // A sample is dropped, and flagged, while the previous word is in flight.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      s_req <= 1'b0;
      s_word <= '0;
      s_tick <= 1'b0;
      s_ovf <= 1'b0;
    end else if (sample_now) begin
      if (s_req != ack_sync[1]) begin
        s_ovf <= 1'b1;
      end else begin
        s_word <= stream_s2;
        s_tick <= epoch_now;
        s_req <= ~s_req;
      end
    end
  end

  // start, eight data bits LSB first, one stop bit.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      rx_state <= sis_pkg::SIS_RX_IDLE;
      baud_cnt <= '0;
      bit_idx <= '0;
      rx_shift <= '0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        sis_pkg::SIS_RX_IDLE: begin
          // A start needs a falling edge, so a low stop bit cannot restart the frame.
          if (aux_s3 && !aux_s2) begin
            baud_cnt <= bd >> 1;
            rx_state <= sis_pkg::SIS_RX_START;
          end
        end
        sis_pkg::SIS_RX_START: begin
          if (baud_cnt != '0) begin
            baud_cnt <= baud_cnt - 11'h001;
          end else if (!aux_s2) begin
            baud_cnt <= bd - 11'h001;
            bit_idx <= '0;
            rx_state <= sis_pkg::SIS_RX_DATA;
          end else begin
            rx_state <= sis_pkg::SIS_RX_IDLE;
          end
        end
        sis_pkg::SIS_RX_DATA: begin
          if (baud_cnt != '0) begin
            baud_cnt <= baud_cnt - 11'h001;
          end else begin
            rx_shift <= {aux_s2, rx_shift[7:1]};
            baud_cnt <= bd - 11'h001;
            bit_idx <= bit_idx + 3'h1;
            if (bit_idx == sis_pkg::AUX_LAST_BIT) begin
              rx_state <= sis_pkg::SIS_RX_STOP;
            end
          end
        end
        sis_pkg::SIS_RX_STOP: begin
          if (baud_cnt != '0) begin
            baud_cnt <= baud_cnt - 11'h001;
          end else begin
            rx_done <= aux_s2;
            rx_state <= sis_pkg::SIS_RX_IDLE;
          end
        end
        default: begin
          rx_state <= sis_pkg::SIS_RX_IDLE;
        end
      endcase
    end
  end

  // byte count per interval capped at 2048.
  always_ff @(posedge sample_clk_i) begin
    if (!lrst_n) begin
      aux_req <= 1'b0;
      aux_hold <= '0;
      aux_ovf <= 1'b0;
      byte_cnt <= '0;
      aux_time <= '0;
    end else if (rx_done) begin
      if (byte_eff >= sis_pkg::AUX_MAX_BYTES || aux_req != aux_ack_sync[1]) begin
        aux_ovf <= 1'b1;
        byte_cnt <= byte_eff;
      end else begin
        aux_hold <= rx_shift;
        aux_req <= ~aux_req;
        aux_time <= {rx_shift, aux_time[31:8]};
        byte_cnt <= byte_eff + 12'h001;
      end
    end else begin
      byte_cnt <= byte_eff;
    end
  end
endmodule

// [sis_stream_input_sampler_sva.sv]
`timescale 1ns/100ps
module sis_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic arm_i,
  input wire logic data_ready_i,
  input wire logic [31:0] data_o,
  input wire logic data_on_tick_o,
  input wire logic data_valid_o,
  input wire logic aux_valid_o,
  input wire logic time_set_o,
  input wire logic sample_overflow_o,
  input wire logic sample_clk_i,
  input wire logic second_tick_in_i,
  input wire logic alternate_second_tick_i,
  input wire logic epoch_monitor_out_o
);
  logic [3:0] arm_age;
  logic [3:0] tick_age;
  // Cycles since the last arm request, saturating.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || arm_i) begin
      arm_age <= 4'h0;
    end else if (arm_age != 4'hF) begin
      arm_age <= arm_age + 4'h1;
    end
  end
  // Sample clocks since either tick pin was last high, saturating.
  always_ff @(posedge sample_clk_i) begin
    if (!rst_n_i || second_tick_in_i || alternate_second_tick_i) begin
      tick_age <= 4'h0;
    end else if (tick_age != 4'hF) begin
      tick_age <= tick_age + 4'h1;
    end
  end
  property p_hold_word;
    @(posedge clk_i) disable iff (!rst_n_i)
      data_valid_o && !data_ready_i |=> $stable(data_o) && $stable(data_on_tick_o);
  endproperty
  a_hold_word: assert property (p_hold_word) else $error("held word changed");
  property p_keep_valid;
    @(posedge clk_i) disable iff (!rst_n_i) data_valid_o && !data_ready_i |=> data_valid_o;
  endproperty
  a_keep_valid: assert property (p_keep_valid) else $error("word lost in stall");
  property p_ovf_sticky;
    @(posedge clk_i) disable iff (!rst_n_i) sample_overflow_o |=> sample_overflow_o;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared");
  property p_aux_pulse;
    @(posedge clk_i) disable iff (!rst_n_i) aux_valid_o |=> !aux_valid_o;
  endproperty
  a_aux_pulse: assert property (p_aux_pulse) else $error("aux valid too long");
  property p_fall_after_arm;
    @(posedge clk_i) disable iff (!rst_n_i) $fell(time_set_o) |-> arm_age < 4'hC;
  endproperty
  a_fall_after_arm: assert property (p_fall_after_arm) else $error("time lost unarmed");
  property p_set_mon;
    @(posedge clk_i) disable iff (!rst_n_i) $rose(time_set_o) |-> ##[0:4] epoch_monitor_out_o;
  endproperty
  a_set_mon: assert property (p_set_mon) else $error("set without monitor");
  property p_mon_tick;
    @(posedge sample_clk_i) disable iff (!rst_n_i) $rose(epoch_monitor_out_o) |-> tick_age < 4'h8;
  endproperty
  a_mon_tick: assert property (p_mon_tick) else $error("monitor without tick");
  property p_mon_len;
    @(posedge sample_clk_i) disable iff (!rst_n_i)
      $rose(epoch_monitor_out_o) |=> epoch_monitor_out_o [*8];
  endproperty
  a_mon_len: assert property (p_mon_len) else $error("monitor pulse short");
  c_on_tick: cover property (@(posedge clk_i) data_valid_o && data_on_tick_o);
  c_set: cover property (@(posedge clk_i) $rose(time_set_o));
  c_aux: cover property (@(posedge clk_i) aux_valid_o);
endmodule
bind sis_stream_input_sampler sis_checker u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .arm_i(arm_i), .data_ready_i(data_ready_i),
  .data_o(data_o), .data_on_tick_o(data_on_tick_o), .data_valid_o(data_valid_o),
  .aux_valid_o(aux_valid_o), .time_set_o(time_set_o), .sample_overflow_o(sample_overflow_o),
  .sample_clk_i(sample_clk_i), .second_tick_in_i(second_tick_in_i),
  .alternate_second_tick_i(alternate_second_tick_i), .epoch_monitor_out_o(epoch_monitor_out_o)
);

// [stream_input_sampler_epoch_bench.sv]
`timescale 1ns/100ps
module stream_input_sampler_epoch_bench;
  logic clk_i = 1'b0;
  logic sample_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  // 64 MHz rate, lowest stream rate
  logic [2:0] rate_sel_i = 3'h5;
  logic [2:0] decim_k_i = 3'h5;
  logic alt_select_i = 1'b0;
  logic arm_i = 1'b0;
  logic [31:0] set_seconds_i = 32'h0000_0000;
  logic data_ready_i = 1'b1;
  logic alt_tick = 1'b0;
  logic tick_req = 1'b0;
  logic byte_req = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic stop_ok = 1'b1;
  logic [31:0] data_o;
  logic [7:0] aux_byte_o;
  logic [7:0] aux_last;
  logic data_on_tick_o, data_valid_o, aux_valid_o, time_set_o;
  logic sample_overflow_o, aux_overflow_o, epoch_monitor_out_o;
  logic tick_pin, serial;
  logic [31:0] lanes;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int aux_seen = 0;
  always #20 clk_i = ~clk_i;
  initial begin
    #3.1;
    forever #7.5 sample_clk_i = ~sample_clk_i;
  end
  sis_stream_input_sampler DUT (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .rate_sel_i(rate_sel_i), .decim_k_i(decim_k_i),
    .alt_select_i(alt_select_i), .auto_time_i(1'b0), .arm_i(arm_i),
    .set_seconds_i(set_seconds_i), .data_ready_i(data_ready_i), .data_o(data_o),
    .data_on_tick_o(data_on_tick_o), .data_valid_o(data_valid_o), .aux_byte_o(aux_byte_o),
    .aux_valid_o(aux_valid_o), .time_set_o(time_set_o), .sample_overflow_o(sample_overflow_o),
    .aux_overflow_o(aux_overflow_o), .sample_clk_i(sample_clk_i), .second_tick_in_i(tick_pin),
    .alternate_second_tick_i(alt_tick), .sample_stream_in_i(lanes), .aux_serial_in_i(serial),
    .epoch_monitor_out_o(epoch_monitor_out_o)
  );
  sis_source_model #(.BIT_CYCLES(64_000_000 / 115_200)) u_src (
    .sample_clk_i(sample_clk_i), .tick_req_i(tick_req), .byte_req_i(byte_req),
    .byte_i(tx_byte), .stop_ok_i(stop_ok), .second_tick_o(tick_pin), .lanes_o(lanes),
    .serial_o(serial)
  );
  always @(posedge clk_i) begin
    cycles++;
    if (aux_valid_o === 1'b1) begin
      aux_seen++;
      aux_last = aux_byte_o;
    end
    if (cycles == 40000) begin
      err_count++;
      close_out();
    end
  end
  function automatic logic [31:0] pat(input int n);
    pat = {n[15:0], ~n[15:0]};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic get_word(output logic [31:0] w, output logic t);
    int n;
    n = 0;
    @(negedge clk_i);
    while (data_valid_o !== 1'b1 && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    w = data_o;
    t = data_on_tick_o;
    @(posedge clk_i);
  endtask
  task automatic reset_dut();
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (20) @(negedge clk_i);
    check("reset outs", {data_valid_o, time_set_o, sample_overflow_o, epoch_monitor_out_o}, 0);
    rst_n_i = 1'b1;
    repeat (10) @(negedge clk_i);
  endtask
  task automatic t_align();
    logic [31:0] w;
    logic t;
    int n;
    @(negedge clk_i);
    tick_req = ~tick_req;
    n = 0;
    t = 1'b0;
    while (t !== 1'b1 && n < 8) begin
      get_word(w, t);
      n++;
    end
    check("on-tick word", w, pat(0));
    for (int i = 1; i < 3; i++) begin
      get_word(w, t);
      check("decimated word", w, pat(32 * i));
      check("tick flag", 32'(t), 0);
    end
  endtask
  task automatic t_stall();
    logic [31:0] w;
    logic t;
    @(negedge clk_i);
    data_ready_i = 1'b0;
    repeat (80) @(negedge clk_i);
    check("held valid", 32'(data_valid_o), 1);
    check("held word", data_o, pat(96));
    check("overflow", 32'(sample_overflow_o), 1);
    data_ready_i = 1'b1;
    @(posedge clk_i);
    get_word(w, t);
    check("second entry", w, pat(128));
  endtask
  task automatic t_aux(input logic [7:0] b, input logic good);
    int n0;
    int n;
    @(negedge clk_i);
    tx_byte = b;
    stop_ok = good;
    byte_req = ~byte_req;
    n0 = aux_seen;
    n = 0;
    while (aux_seen == n0 && n < 3000) begin
      @(negedge clk_i);
      n++;
    end
    check("aux count", 32'(aux_seen - n0), 32'(good));
    if (good) begin
      check("aux byte", 32'(aux_last), 32'(b));
    end
  endtask
  task automatic t_arm(input logic alt);
    int n;
    @(negedge clk_i);
    alt_select_i = alt;
    set_seconds_i = 32'h0000_1234;
    arm_i = 1'b1;
    @(negedge clk_i);
    arm_i = 1'b0;
    repeat (20) @(negedge clk_i);
    check("armed, not set", 32'(time_set_o), 0);
    if (alt) begin
      alt_tick = 1'b1;
      repeat (2) @(negedge clk_i);
      alt_tick = 1'b0;
    end else begin
      tick_req = ~tick_req;
    end
    repeat (30) @(negedge clk_i);
    check("time set", 32'(time_set_o), 1);
    check("monitor", 32'(epoch_monitor_out_o), 1);
    if (!alt) begin
      tick_req = ~tick_req;
      n = 0;
      repeat (100) begin
        @(negedge clk_i);
        n += int'(data_valid_o === 1'b1 && data_on_tick_o === 1'b1);
      end
      check("tick ignored", 32'(n), 0);
      check("still set", 32'(time_set_o), 1);
    end
  endtask
  initial begin
    reset_dut();
    t_align();
    t_stall();
    // three bytes, one with a low stop bit, well under the burst limit
    t_aux(8'hA5, 1'b1);
    t_aux(8'h3C, 1'b0);
    t_aux(8'h5A, 1'b1);
    check("aux overflow", 32'(aux_overflow_o), 0);
    t_arm(1'b0);
    // alternate setting last, never re-armed afterwards
    t_arm(1'b1);
    reset_dut();
    close_out();
  end
endmodule
